/* File: core/dpr_host.sv */
// Controller for one port of a shared two-port memory with semaphores and message flags.
`timescale 1ns/100ps
`include "dpr_defs.svh"
// How it works
// - Array access uses chip select low; read direction high, write direction low.
// - Semaphores use flag latch select low with chip select high, never both low.
// - Every semaphore gets a one written at start-up before use.
// - After a semaphore take write, release selects for recovery, read back, poll while one.
// - Writes wait until busy has settled and are not strobed while busy.
module dpr_host (
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     cmd_valid,
    output logic                          cmd_ready,
    input  wire dpr_pkg::dpr_op_type      cmd_op,
    input  wire logic [`DPR_ADDR_W-1:0]   cmd_addr,
    input  wire logic [`DPR_DATA_W-1:0]   cmd_wdata,
    output logic                          resp_valid,
    output logic      [`DPR_DATA_W-1:0]   resp_rdata,
    output logic                          init_done,
    output logic                          message_pending,
    output logic      [`DPR_ADDR_W-1:0]   port_addr,
    output logic      [`DPR_DATA_W-1:0]   port_data_out,
    output logic                          port_data_oe,
    input  wire logic [`DPR_DATA_W-1:0]   port_data_in,
    output logic                          chip_select_n,
    output logic                          flag_latch_select_n,
    output logic                          output_drive_n,
    output logic                          transfer_dir,
    input  wire logic                     contention_flag_n,
    input  wire logic                     message_flag_n
);
    import dpr_pkg::*;

    typedef enum logic [2:0] {
        TP_INIT = 3'b001,
        TP_IDLE = 3'b010,
        TP_RUN  = 3'b100
    } dpr_top_type;

    dpr_top_type                 state;
    dpr_op_type                  op;
    logic                        sem_readback;
    logic [`DPR_SEM_IDX_W-1:0]   init_idx;
    logic                        msg_meta;
    logic                        msg_sync;

    dpr_cyc_if cyc ();

    dpr_pin_seq u_seq (
        .core_clk            (core_clk),
        .sys_rst             (sys_rst),
        .cyc                 (cyc.seq),
        .port_addr           (port_addr),
        .port_data_out       (port_data_out),
        .port_data_oe        (port_data_oe),
        .port_data_in        (port_data_in),
        .chip_select_n       (chip_select_n),
        .flag_latch_select_n (flag_latch_select_n),
        .output_drive_n      (output_drive_n),
        .transfer_dir        (transfer_dir),
        .contention_flag_n   (contention_flag_n)
    );

    // The message flag is a pin level from the far side, so it is synchronised first.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            msg_meta        <= 1'b1;
            msg_sync        <= 1'b1;
            message_pending <= 1'b0;
        end else begin
            msg_meta        <= message_flag_n;
            msg_sync        <= msg_meta;
            message_pending <= !msg_sync;
        end
    end

    // Command handling; the request line is held until the sequencer reports done.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state        <= TP_INIT;
            op           <= DPR_OP_READ;
            sem_readback <= 1'b0;
            init_idx     <= '0;
            init_done    <= 1'b0;
            cmd_ready    <= 1'b0;
            resp_valid   <= 1'b0;
            resp_rdata   <= '0;
            cyc.req      <= 1'b0;
            cyc.is_sem   <= 1'b1;
            cyc.is_write <= 1'b1;
            cyc.addr     <= '0;
            cyc.wdata    <= `DPR_FREE_BYTE;
        end else begin
            resp_valid <= 1'b0;
            case (state)
                TP_INIT: begin
                    // the latches are not cleared by the part, so each one is written free.
                    cyc.is_sem   <= 1'b1;
                    cyc.is_write <= 1'b1;
                    cyc.wdata    <= `DPR_FREE_BYTE;
                    cyc.addr     <= {`DPR_SEM_PAD, init_idx};
                    cyc.req      <= !cyc.done;
                    if (cyc.done) begin
                        if (init_idx == `DPR_LAST_SEM) begin
                            state     <= TP_IDLE;
                            init_done <= 1'b1;
                            cmd_ready <= 1'b1;
                        end else begin
                            init_idx <= init_idx + 1'b1;
                        end
                    end
                end
                TP_IDLE: begin
                    if (cmd_valid) begin
                        op           <= cmd_op;
                        sem_readback <= 1'b0;
                        cmd_ready    <= 1'b0;
                        cyc.req      <= 1'b1;
                        cyc.is_sem   <= (cmd_op == DPR_OP_SEM_TAKE) || (cmd_op == DPR_OP_SEM_RELEASE);
                        cyc.is_write <= (cmd_op != DPR_OP_READ);
                        cyc.addr     <= cmd_addr;
                        // a semaphore write carries its value on data bit zero.
                        case (cmd_op)
                            DPR_OP_SEM_TAKE:    cyc.wdata <= `DPR_TAKE_BYTE;
                            DPR_OP_SEM_RELEASE: cyc.wdata <= `DPR_FREE_BYTE;
                            default:            cyc.wdata <= cmd_wdata;
                        endcase
                        state <= TP_RUN;
                    end
                end
                TP_RUN: begin
                    if (cyc.done) begin
                        if (cyc.retry) begin
                            // an array read or write refused under busy is simply run again.
                            cyc.req <= 1'b1;
                        end else if (op == DPR_OP_SEM_TAKE && !sem_readback) begin
                            // after the recovery gap, read the latch back.
                            sem_readback <= 1'b1;
                            cyc.is_write <= 1'b0;
                            cyc.req      <= 1'b1;
                        end else if (op == DPR_OP_SEM_TAKE && cyc.rdata[0] != `DPR_SEM_TAKE) begin
                            // still held by the far side, keep polling.
                            cyc.req <= 1'b1;
                        end else begin
                            cyc.req    <= 1'b0;
                            resp_valid <= 1'b1;
                            resp_rdata <= cyc.rdata;
                            cmd_ready  <= 1'b1;
                            state      <= TP_IDLE;
                        end
                    end
                end
                default: begin
                    state   <= TP_IDLE;
                    cyc.req <= 1'b0;
                end
            endcase
        end
    end

    a_cmd_after_init: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(init_done) |-> $past(cyc.done) && ($past(init_idx) == `DPR_LAST_SEM))
        else $error("commands opened before every latch was freed");
    a_init_writes_free: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == TP_INIT) && cyc.req |-> cyc.is_sem && cyc.is_write && cyc.wdata[0])
        else $error("init cycle is not a semaphore free write");
    a_take_ends_owned: assert property (@(posedge core_clk) disable iff (sys_rst)
        resp_valid && (op == DPR_OP_SEM_TAKE) |-> !resp_rdata[0] && sem_readback)
        else $error("take answered without ownership");
endmodule

/* File: pkg/dpr_defs.svh */
// Constants for the dual-port memory port controller: pin timing, widths and semaphore values.
`ifndef DPR_DEFS_SVH
`define DPR_DEFS_SVH

`define DPR_ADDR_W        13
`define DPR_DATA_W        8
`define DPR_CNT_W         4
`define DPR_SEM_IDX_W     3
`define DPR_NUM_SEMS      8
`define DPR_LAST_SEM      3'h7
`define DPR_SEM_FREE      1'b1
`define DPR_SEM_TAKE      1'b0
`define DPR_FREE_BYTE     8'hff
`define DPR_TAKE_BYTE     8'h00
`define DPR_SEM_PAD       10'h000
`define DPR_MBOX_LEFT     13'h1ffe
`define DPR_MBOX_RIGHT    13'h1fff

// Clock period and pin phase lengths in nanoseconds.
`define DPR_CLK_PERIOD_NS 8
`define DPR_SETTLE_NS     24
`define DPR_STROBE_NS     40
`define DPR_RECOVER_NS    24

// Least times round up to whole cycles.
`define DPR_CYCLES(ns)    (((ns) + `DPR_CLK_PERIOD_NS - 1) / `DPR_CLK_PERIOD_NS)
`define DPR_SETTLE_CYC    `DPR_CYCLES(`DPR_SETTLE_NS)
`define DPR_STROBE_CYC    `DPR_CYCLES(`DPR_STROBE_NS)
`define DPR_RECOVER_CYC   `DPR_CYCLES(`DPR_RECOVER_NS)

`endif

/* File: pkg/dpr_pkg.sv */
// Types shared by the dual-port memory port controller.
package dpr_pkg;
    typedef enum logic [1:0] {
        DPR_OP_READ        = 2'h0,
        DPR_OP_WRITE       = 2'h1,
        DPR_OP_SEM_TAKE    = 2'h2,
        DPR_OP_SEM_RELEASE = 2'h3
    } dpr_op_type;
endpackage

/* File: pkg/dpr_cyc_if.sv */
// Interface carrying one pin cycle request and its answer between the controller and the pin sequencer.
`timescale 1ns/100ps
interface dpr_cyc_if;
    logic       req;
    logic       is_sem;
    logic       is_write;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic       done;
    logic       retry;
    logic [7:0] rdata;

    modport ctl (output req, output is_sem, output is_write, output addr, output wdata,
                 input done, input retry, input rdata);
    modport seq (input req, input is_sem, input is_write, input addr, input wdata,
                 output done, output retry, output rdata);
endinterface

/* File: core/dpr_pin_seq.sv */
// Pin sequencer that runs one array or semaphore cycle on a memory port.
`timescale 1ns/100ps
`include "dpr_defs.svh"
module dpr_pin_seq (
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    dpr_cyc_if.seq                        cyc,
    output logic      [`DPR_ADDR_W-1:0]   port_addr,
    output logic      [`DPR_DATA_W-1:0]   port_data_out,
    output logic                          port_data_oe,
    input  wire logic [`DPR_DATA_W-1:0]   port_data_in,
    output logic                          chip_select_n,
    output logic                          flag_latch_select_n,
    output logic                          output_drive_n,
    output logic                          transfer_dir,
    input  wire logic                     contention_flag_n
);
    import dpr_pkg::*;

    typedef enum logic [3:0] {
        SQ_IDLE    = 4'b0001,
        SQ_SETUP   = 4'b0010,
        SQ_STROBE  = 4'b0100,
        SQ_RECOVER = 4'b1000
    } dpr_sq_type;

    dpr_sq_type              state;
    dpr_sq_type              next_state;
    logic [`DPR_CNT_W-1:0]   cnt;
    logic [`DPR_CNT_W-1:0]   next_cnt;
    logic                    next_retry;
    logic [`DPR_DATA_W-1:0]  data_meta;
    logic [`DPR_DATA_W-1:0]  data_sync;
    logic                    busy_meta;
    logic                    busy_sync;

    // Pin inputs pass two flip-flops before anything looks at them.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_meta <= `DPR_FREE_BYTE;
            data_sync <= `DPR_FREE_BYTE;
            busy_meta <= 1'b1;
            busy_sync <= 1'b1;
        end else begin
            data_meta <= port_data_in;
            data_sync <= data_meta;
            busy_meta <= contention_flag_n;
            busy_sync <= busy_meta;
        end
    end

    // Phase sequencing; the busy check happens once the select has settled.
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_retry = 1'b0;
        case (state)
            SQ_IDLE: begin
                if (cyc.req && !cyc.done) begin
                    next_state = SQ_SETUP;
                    next_cnt   = `DPR_CNT_W'(`DPR_SETTLE_CYC - 1);
                end
            end
            SQ_SETUP: begin
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else if (!cyc.is_sem && !busy_sync) begin
                    // busy settled low, skip the strobe and retry.
                    next_state = SQ_RECOVER;
                    next_retry = 1'b1;
                    next_cnt   = `DPR_CNT_W'(`DPR_RECOVER_CYC - 1);
                end else begin
                    next_state = SQ_STROBE;
                    next_cnt   = `DPR_CNT_W'(`DPR_STROBE_CYC - 1);
                end
            end
            SQ_STROBE: begin
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else begin
                    next_state = SQ_RECOVER;
                    next_cnt   = `DPR_CNT_W'(`DPR_RECOVER_CYC - 1);
                end
            end
            SQ_RECOVER: begin
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else begin
                    next_state = SQ_IDLE;
                end
            end
            default: begin
                next_state = SQ_IDLE;
                next_cnt   = '0;
            end
        endcase
    end

    // State, counter and answer flags.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= SQ_IDLE;
            cnt       <= '0;
            cyc.done  <= 1'b0;
            cyc.retry <= 1'b0;
            cyc.rdata <= '0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            cyc.done <= (state == SQ_RECOVER) && (next_state == SQ_IDLE);
            if (next_retry) begin
                cyc.retry <= 1'b1;
            end else if (state == SQ_IDLE) begin
                cyc.retry <= 1'b0;
            end
            // Data is sampled at the end of the strobe, after the synchroniser has caught up.
            if (state == SQ_STROBE && next_state == SQ_RECOVER) begin
                cyc.rdata <= data_sync;
            end
        end
    end

    // Pin drive follows the next phase so every pin leaves a flip-flop.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_addr           <= '0;
            port_data_out       <= '0;
            port_data_oe        <= 1'b0;
            chip_select_n       <= 1'b1;
            flag_latch_select_n <= 1'b1;
            output_drive_n      <= 1'b1;
            transfer_dir        <= 1'b1;
        end else begin
            if (state == SQ_IDLE) begin
                port_addr     <= cyc.addr;
                port_data_out <= cyc.wdata;
            end
            // only one select goes low, and only for the access phases.
            chip_select_n       <= !(!cyc.is_sem && (next_state == SQ_SETUP || next_state == SQ_STROBE));
            flag_latch_select_n <= !(cyc.is_sem && (next_state == SQ_SETUP || next_state == SQ_STROBE));
            port_data_oe        <= cyc.is_write && (next_state == SQ_SETUP || next_state == SQ_STROBE);
            // write strobes direction low; read strobes the output drive low with direction high.
            transfer_dir        <= !(cyc.is_write && next_state == SQ_STROBE);
            output_drive_n      <= !(!cyc.is_write && next_state == SQ_STROBE);
        end
    end

    sequence s_select_released;
        flag_latch_select_n && output_drive_n;
    endsequence

    a_select_exclusive: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(!chip_select_n && !flag_latch_select_n)) else $error("both selects low");
    a_write_has_select: assert property (@(posedge core_clk) disable iff (sys_rst)
        !transfer_dir |-> (chip_select_n ^ flag_latch_select_n) && port_data_oe)
        else $error("write strobe without one select");
    a_read_dir_high: assert property (@(posedge core_clk) disable iff (sys_rst)
        !output_drive_n |-> transfer_dir && !port_data_oe) else $error("read with direction low");
    a_sem_recovery_gap: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(flag_latch_select_n) |-> s_select_released [*3]) else $error("semaphore recovery too short");
    a_busy_settled_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(transfer_dir) && !chip_select_n |-> $past(busy_sync)) else $error("write under contention");
endmodule

/* File: tb/dpr_mem_model.sv */
// Behavioural two-port memory with semaphores, message flags and busy arbitration.
`timescale 1ns/100ps
module dpr_mem_model (
    input  wire logic        core_clk,
    input  wire logic [12:0] port_addr,
    input  wire logic [7:0]  port_data_out,
    input  wire logic        port_data_oe,
    output logic      [7:0]  port_data_in,
    input  wire logic        chip_select_n,
    input  wire logic        flag_latch_select_n,
    input  wire logic        output_drive_n,
    input  wire logic        transfer_dir,
    output logic             contention_flag_n,
    output logic             message_flag_n,
    output logic             right_message_flag_n,
    input  wire logic        right_active,
    input  wire logic [12:0] right_addr,
    input  wire logic [7:0]  right_wdata,
    input  wire logic        right_we,
    input  wire logic        right_rd,
    input  wire logic        right_sem_we,
    input  wire logic        right_sem_bit
);
    logic [7:0]  mem [8192];
    // latches kept apart from the array
    logic [7:0]  own [2] = '{8'h3c, 8'h00};
    logic [7:0]  pend [2] = '{8'h00, 8'h00};
    logic [7:0]  inited = 8'h00;
    logic [7:0]  sem_hold = 8'h00;
    logic [7:0]  last = 8'h00;
    int          busy_hits = 0;
    logic [12:0] p_addr;
    logic [7:0]  p_dout;
    logic [4:0]  p_pins;

    initial begin
        message_flag_n = 1'b1;
        right_message_flag_n = 1'b1;
    end

    // grant, hand over or hold a request; one side at a time.
    task automatic sem_write(input int s, input logic [2:0] i, input logic b);
        if (!b) begin
            if (!own[1-s][i]) own[s][i] = 1'b1;
            else pend[s][i] = 1'b1;
        end else begin
            pend[s][i] = 1'b0;
            if (s == 0) inited[i] = 1'b1;
            if (own[s][i]) begin
                own[s][i] = 1'b0;
                own[1-s][i] = pend[1-s][i];
                pend[1-s][i] = 1'b0;
            end
        end
    endtask

    // the far port holds the location, so the near port is busy.
    assign contention_flag_n = !(right_active && !chip_select_n && port_addr == right_addr);

    // drive only on a legal read; a floating bus shows a changing pattern.
    always_comb begin
        if (!output_drive_n && transfer_dir && !chip_select_n && flag_latch_select_n)
            port_data_in = mem[port_addr];
        else if (!output_drive_n && transfer_dir && !flag_latch_select_n && chip_select_n)
            port_data_in = sem_hold;
        else
            port_data_in = ~last;
    end

    // Pin events are judged from the previous cycle, so a write lands on the direction's rising edge.
    always @(posedge core_clk) begin
        last <= port_data_in;
        p_addr <= port_addr;
        p_dout <= port_data_oe ? port_data_out : ~last;
        p_pins <= {chip_select_n, flag_latch_select_n, transfer_dir, output_drive_n, contention_flag_n};
        if (!contention_flag_n) busy_hits <= busy_hits + 1;
        // latch value is frozen in an output register at the start of the read
        if (!flag_latch_select_n && !output_drive_n && p_pins[1])
            sem_hold <= {8{!own[0][port_addr[2:0]]}};
        // array write unless busy, latch write from data bit zero
        if (transfer_dir && !p_pins[2]) begin
            if (!p_pins[4] && p_pins[3] && p_pins[0]) begin
                mem[p_addr] <= p_dout;
                if (p_addr == 13'h1fff) right_message_flag_n <= 1'b0;
            end else if (!p_pins[3] && p_pins[4])
                sem_write(0, p_addr[2:0], p_dout[0]);
        end
        // a local read of the mailbox clears the local flag, data kept
        if (output_drive_n && !p_pins[1] && !p_pins[4] && p_addr == 13'h1ffe) message_flag_n <= 1'b1;
        if (right_we) begin
            mem[right_addr] <= right_wdata;
            if (right_addr == 13'h1ffe) message_flag_n <= 1'b0;
        end
        if (right_rd && right_addr == 13'h1fff) right_message_flag_n <= 1'b1;
        if (right_sem_we) sem_write(1, right_addr[2:0], right_sem_bit);
    end
endmodule

/* File: tb/dpr_host_bench.sv */
// Self-checking bench for the memory port controller against a two-port memory model.
`timescale 1ns/100ps
`include "dpr_defs.svh"
module dpr_host_bench;
    import dpr_pkg::*;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cmd_valid = 1'b0;
    dpr_op_type  cmd_op = DPR_OP_READ;
    logic [12:0] cmd_addr = 13'h0000;
    logic [7:0]  cmd_wdata = 8'h00;
    logic        cmd_ready, resp_valid, init_done, message_pending, port_data_oe;
    logic [7:0]  resp_rdata, port_data_out, port_data_in, right_wdata = 8'h00, d;
    logic [12:0] port_addr, a, right_addr = 13'h0000;
    logic        chip_select_n, flag_latch_select_n, output_drive_n, transfer_dir;
    logic        contention_flag_n, message_flag_n, right_message_flag_n;
    logic        right_active = 1'b0, right_we = 1'b0, right_rd = 1'b0;
    logic        right_sem_we = 1'b0, right_sem_bit = 1'b0;
    logic [8:0]  exp_q [$];
    logic [8:0]  note;
    int          errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          seed = 32'hd606;

    dpr_host i_dut (.core_clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata,
        .resp_valid, .resp_rdata, .init_done, .message_pending, .port_addr, .port_data_out,
        .port_data_oe, .port_data_in, .chip_select_n, .flag_latch_select_n, .output_drive_n,
        .transfer_dir, .contention_flag_n, .message_flag_n);
    dpr_mem_model i_mem (.core_clk, .port_addr, .port_data_out, .port_data_oe, .port_data_in,
        .chip_select_n, .flag_latch_select_n, .output_drive_n, .transfer_dir, .contention_flag_n,
        .message_flag_n, .right_message_flag_n, .right_active, .right_addr, .right_wdata,
        .right_we, .right_rd, .right_sem_we, .right_sem_bit);

    // Free-running clock at 125 MHz.
    always #4 core_clk = ~core_clk;

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // One command: note the expectation, hold the request until taken, wait for the answer.
    task automatic do_cmd(input dpr_op_type op, input logic [12:0] ad, input logic [7:0] wd,
                          input logic chk, input logic [7:0] e);
        exp_q.push_back({chk, e});
        cmd_op <= op;
        cmd_addr <= ad;
        cmd_wdata <= wd;
        cmd_valid <= 1'b1;
        @(posedge core_clk);
        while (cmd_ready !== 1'b1) @(posedge core_clk);
        cmd_valid <= 1'b0;
        @(posedge core_clk iff resp_valid === 1'b1);
    endtask

    // One far-port action lasting a single cycle.
    task automatic right_op(input logic [12:0] ad, input logic [7:0] wd, input logic [2:0] act, input logic b);
        right_addr <= ad;
        right_wdata <= wd;
        {right_we, right_rd, right_sem_we} <= act;
        right_sem_bit <= b;
        @(posedge core_clk);
        {right_we, right_rd, right_sem_we} <= 3'h0;
        @(posedge core_clk);
    endtask

    // Answers are matched in order against the oldest note once settled.
    always @(negedge core_clk) begin
        if (resp_valid === 1'b1) begin
            if (exp_q.size() == 0) check("answer count", 8'h01, 8'h00);
            else begin
                note = exp_q.pop_front();
                if (note[8]) check("answer data", resp_rdata, note[7:0]);
            end
        end
    end

    // A hung run is cut short well beyond the expected length.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        // the far side frees every latch as well
        for (int i = 0; i < 8; i++) right_op(13'(i), 8'h00, 3'h1, 1'b1);
        @(posedge core_clk iff init_done === 1'b1);
        check("latches freed", i_mem.inited, 8'hff);
        check("left ownership", i_mem.own[0], 8'h00);
        $display("test start-up done");
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1ffd : {5'h08, 8'($random(seed))};
            d = 8'($random(seed));
            do_cmd(DPR_OP_WRITE, a, d, 1'b0, 8'h00);
            do_cmd(DPR_OP_READ, a, 8'h00, 1'b1, d);
        end
        $display("test array done");
        do_cmd(DPR_OP_WRITE, 13'h1ff3, 8'h5a, 1'b0, 8'h00);
        do_cmd(DPR_OP_SEM_TAKE, 13'h1ff3, 8'h00, 1'b1, 8'h00);
        check("owner of latch 3", i_mem.own[0], 8'h08);
        do_cmd(DPR_OP_READ, 13'h1ff3, 8'h00, 1'b1, 8'h5a);
        right_op(13'h0003, 8'h00, 3'h1, 1'b0);
        check("far request denied", i_mem.own[1], 8'h00);
        do_cmd(DPR_OP_SEM_RELEASE, 13'h0003, 8'hff, 1'b0, 8'h00);
        check("latch 3 handed over", i_mem.own[1], 8'h08);
        right_op(13'h0003, 8'h00, 3'h1, 1'b1);
        right_op(13'h0005, 8'h00, 3'h1, 1'b0);
        fork
            do_cmd(DPR_OP_SEM_TAKE, 13'h0005, 8'h00, 1'b1, 8'h00);
            begin
                repeat (150) @(posedge core_clk);
                check("left still waiting", exp_q.size(), 8'h01);
                right_op(13'h0005, 8'h00, 3'h1, 1'b1);
            end
        join
        check("left took latch 5", i_mem.own[0], 8'h20);
        do_cmd(DPR_OP_SEM_RELEASE, 13'h0005, 8'hff, 1'b0, 8'h00);
        check("all latches free", i_mem.own[0] | i_mem.own[1], 8'h00);
        $display("test semaphores done");
        do_cmd(DPR_OP_WRITE, `DPR_MBOX_RIGHT, 8'h3c, 1'b0, 8'h00);
        check("far flag set", right_message_flag_n, 1'b0);
        right_op(`DPR_MBOX_RIGHT, 8'h00, 3'h2, 1'b0);
        check("far flag cleared", right_message_flag_n, 1'b1);
        check("message kept", i_mem.mem[13'h1fff], 8'h3c);
        d = 8'($random(seed));
        right_op(`DPR_MBOX_LEFT, d, 3'h4, 1'b0);
        repeat (4) @(posedge core_clk);
        check("message pending", message_pending, 1'b1);
        do_cmd(DPR_OP_READ, `DPR_MBOX_LEFT, 8'h00, 1'b1, d);
        repeat (4) @(posedge core_clk);
        check("message cleared", message_pending, 1'b0);
        $display("test mailbox done");
        do_cmd(DPR_OP_WRITE, 13'h0100, 8'h77, 1'b0, 8'h00);
        right_addr <= 13'h0100;
        right_active <= 1'b1;
        fork
            do_cmd(DPR_OP_WRITE, 13'h0100, 8'ha5, 1'b0, 8'h00);
            begin
                repeat (60) @(posedge core_clk);
                check("busy seen", 8'(i_mem.busy_hits != 0), 8'h01);
                check("write held off", i_mem.mem[13'h0100], 8'h77);
                right_active <= 1'b0;
            end
        join
        do_cmd(DPR_OP_READ, 13'h0100, 8'h00, 1'b1, 8'ha5);
        $display("test contention done");
        print_verdict();
    end
endmodule
